// File: rtl/cbsc_regs.svh
// register offsets, field positions, reset values and thresholds of the channel b pin block
`ifndef CBSC_REGS_SVH
`define CBSC_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CBSC_OFF_CTRL      8'h00
`define CBSC_OFF_STATUS    8'h04
`define CBSC_OFF_IRQ_STAT  8'h08
`define CBSC_OFF_IRQ_MASK  8'h0c
`define CBSC_OFF_CMD       8'h10
`define CBSC_OFF_REFSEL    8'h14

// ------------------------------------------------------------
// ctrl fields
// ------------------------------------------------------------
`define CBSC_CTRL_LOS_EN   0
`define CBSC_CTRL_PD       1
`define CBSC_CTRL_ROUTE_LO 2
`define CBSC_CTRL_ROUTE_HI 3
`define CBSC_CTRL_W        4
`define CBSC_CTRL_RST      4'h1

// ------------------------------------------------------------
// refsel fields, cmd fields
// ------------------------------------------------------------
`define CBSC_REF_SW_MODE   0
`define CBSC_REF_SW_ONE    1
`define CBSC_REF_W         2
`define CBSC_REF_RST       2'h0
`define CBSC_CMD_DP_RST    0

// ------------------------------------------------------------
// status and interrupt bits
// ------------------------------------------------------------
`define CBSC_ST_LOSS       0
`define CBSC_ST_PD         1
`define CBSC_ST_REF_ONE    2
`define CBSC_ST_LANE_LO    4
`define CBSC_IRQ_W         4
`define CBSC_IRQ_RST       4'h0
`define CBSC_EV_LOSS_SET   0
`define CBSC_EV_LOSS_CLR   1
`define CBSC_EV_ROTATE     2
`define CBSC_EV_PD_REL     3

// ------------------------------------------------------------
// swing thresholds in millivolts peak to peak
// ------------------------------------------------------------
`define CBSC_LOS_ASSERT_MV   10'd75
`define CBSC_LOS_DEASSERT_MV 10'd150

`endif

// File: rtl/cbsc_pkg.sv
// types shared by the channel b pin block
package cbsc_pkg;

    // source routed onto the loss pin
    typedef enum logic [1:0] {
        CBSC_ROUTE_LOSS,
        CBSC_ROUTE_ROTATE,
        CBSC_ROUTE_PWRDN,
        CBSC_ROUTE_REFSEL
    } cbsc_route_type;

    // loss detector state
    typedef enum logic {
        CBSC_LOS_PRESENT,
        CBSC_LOS_LOST
    } cbsc_los_type;

endpackage

// File: rtl/cbsc_jog_sync.sv
// synchroniser and toggle detector for the lane rotation jog pin
`timescale 1ns/1ps
`default_nettype none

module cbsc_jog_sync #(
    parameter int STAGES = 2
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic jog_in,
    output logic      jog_pulse
);

    logic [STAGES-1:0] sync_r;
    logic              prev_r;
    logic              pulse_r;
    wire logic         jog_s = sync_r[STAGES-1];
    wire logic         edge_s = jog_s ^ prev_r;

    // ------------------------------------------------------------
    // synchroniser chain, first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_r <= '0;
        end else begin
            sync_r <= {sync_r[STAGES-2:0], jog_in};
        end
    end

    // either direction of toggle gives one pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r  <= 1'b0;
            pulse_r <= 1'b0;
        end else begin
            prev_r  <= jog_s;
            pulse_r <= edge_s;
        end
    end

    assign jog_pulse = pulse_r;

    AST_JOG_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        (jog_s != prev_r) |=> jog_pulse)
        else $error("jog toggle gave no rotate pulse");

    AST_JOG_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        (jog_s == prev_r) |=> !jog_pulse)
        else $error("rotate pulse without a jog toggle");

endmodule

`default_nettype wire

// File: rtl/cbsc_top.sv
// channel b status and control pins: loss flag, lane jog, power down, reference select
`timescale 1ns/1ps
`default_nettype none
`include "cbsc_regs.svh"

module cbsc_top
    import cbsc_pkg::*;
#(
    parameter int LANES     = 4,
    parameter int LANE_W    = 2,
    parameter int SYNC_STGS = 2
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [9:0]        hs_rx_swing_mv,
    input  wire logic              lane_rotate_jog,
    input  wire logic              chan_powerdown_n,
    input  wire logic              shared_refsel_pin,
    input  wire logic              chan_b_refsel_pin,
    output logic                   rx_signal_loss_flag,
    output logic                   rx_signal_loss_flag_oe_n,
    output logic      [LANE_W-1:0] lane_rotate_sel,
    output logic                   chan_powered_down,
    output logic                   ref_sel_one,
    output logic                   datapath_reset,
    output logic                   irq
);

    // ------------------------------------------------------------
    // address decode helper, shared by read and write paths
    // ------------------------------------------------------------
    function automatic logic cbsc_hit(input logic [7:0] addr, input logic [7:0] off);
        cbsc_hit = (addr == off);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [`CBSC_CTRL_W-1:0] ctrl_r;
    logic [`CBSC_REF_W-1:0]  refsel_r;
    logic [`CBSC_IRQ_W-1:0]  irq_stat_r;
    logic [`CBSC_IRQ_W-1:0]  irq_mask_r;
    logic [31:0]             prdata_r;
    logic                    pready_r;
    logic                    pslverr_r;
    cbsc_los_type            los_r;
    logic                    loss_prev_r;
    logic                    pin_pd_r;
    logic                    flag_r;
    logic                    flag_oe_n_r;
    logic [LANE_W-1:0]       lane_r;
    logic                    pd_r;
    logic                    ref_one_r;
    logic                    dp_rst_r;
    logic                    irq_r;

    // ------------------------------------------------------------
    // apb decode: one wait state, pready is a flop
    // ------------------------------------------------------------
    wire logic acc       = psel & penable;
    wire logic first_acc = acc & ~pready_r;
    wire logic done      = acc & pready_r;
    wire logic wr_done   = done & pwrite;
    wire logic rd_done   = done & ~pwrite;
    wire logic hit_ctrl  = cbsc_hit(paddr, `CBSC_OFF_CTRL);
    wire logic hit_stat  = cbsc_hit(paddr, `CBSC_OFF_STATUS);
    wire logic hit_istat = cbsc_hit(paddr, `CBSC_OFF_IRQ_STAT);
    wire logic hit_imask = cbsc_hit(paddr, `CBSC_OFF_IRQ_MASK);
    wire logic hit_cmd   = cbsc_hit(paddr, `CBSC_OFF_CMD);
    wire logic hit_ref   = cbsc_hit(paddr, `CBSC_OFF_REFSEL);
    wire logic hit_any   = hit_ctrl | hit_stat | hit_istat | hit_imask | hit_cmd | hit_ref;

    // ------------------------------------------------------------
    // control field views
    // ------------------------------------------------------------
    wire logic           los_en    = ctrl_r[`CBSC_CTRL_LOS_EN];
    wire logic           reg_pd    = ctrl_r[`CBSC_CTRL_PD];
    wire cbsc_route_type route     = cbsc_route_type'(ctrl_r[`CBSC_CTRL_ROUTE_HI:`CBSC_CTRL_ROUTE_LO]);
    wire logic           sw_mode   = refsel_r[`CBSC_REF_SW_MODE];
    wire logic           sw_one    = refsel_r[`CBSC_REF_SW_ONE];
    wire logic           pd_any    = ~chan_powerdown_n | reg_pd;
    wire logic           low_swing = (hs_rx_swing_mv <= `CBSC_LOS_ASSERT_MV);
    wire logic           hi_swing  = (hs_rx_swing_mv > `CBSC_LOS_DEASSERT_MV);
    wire logic           loss_lvl  = (los_r == CBSC_LOS_LOST);

    // ------------------------------------------------------------
    // jog synchroniser and rotate pulse
    // ------------------------------------------------------------
    logic rot_pulse;

    cbsc_jog_sync #(
        .STAGES (SYNC_STGS)
    ) u_jog (
        .pclk      (pclk),
        .presetn   (presetn),
        .jog_in    (lane_rotate_jog),
        .jog_pulse (rot_pulse)
    );

    // ------------------------------------------------------------
    // loss detector: hysteresis, swing between thresholds holds state
    // ------------------------------------------------------------
    cbsc_los_type los_nxt;

    always_comb begin
        los_nxt = los_r;
        case (los_r)
            CBSC_LOS_PRESENT: begin
                if (los_en && low_swing) begin
                    los_nxt = CBSC_LOS_LOST;
                end
            end
            CBSC_LOS_LOST: begin
                if (!los_en || hi_swing) begin
                    los_nxt = CBSC_LOS_PRESENT;
                end
            end
            default: los_nxt = CBSC_LOS_PRESENT;
        endcase
    end

    // ------------------------------------------------------------
    // pin mux: routed source, floated in power down
    // ------------------------------------------------------------
    logic routed_val;

    always_comb begin
        case (route)
            CBSC_ROUTE_LOSS:   routed_val = loss_lvl;
            CBSC_ROUTE_ROTATE: routed_val = lane_r[0];
            CBSC_ROUTE_PWRDN:  routed_val = pd_r;
            CBSC_ROUTE_REFSEL: routed_val = ref_one_r;
            default:           routed_val = loss_lvl;
        endcase
    end

    // driven low when floating so the pad sees a quiet level
    wire logic flag_nxt      = pd_any ? 1'b0 : routed_val;
    wire logic flag_oe_n_nxt = pd_any;

    // ------------------------------------------------------------
    // lane rotation and reference select
    // ------------------------------------------------------------
    wire logic [LANE_W-1:0] lane_last = LANE_W'(LANES - 1);
    wire logic [LANE_W-1:0] lane_inc  = lane_r + 1'b1;
    wire logic [LANE_W-1:0] lane_nxt  = !rot_pulse ? lane_r :
                                        (lane_r == lane_last) ? '0 : lane_inc;
    // in pin mode, per-channel pin forces reference zero; shared pin otherwise decides
    wire logic pin_one = shared_refsel_pin & ~chan_b_refsel_pin;
    wire logic ref_nxt = sw_mode ? sw_one : pin_one;

    // ------------------------------------------------------------
    // interrupt events: set beats a read clear in the same cycle
    // ------------------------------------------------------------
    logic [`CBSC_IRQ_W-1:0] ev;

    always_comb begin
        ev = '0;
        ev[`CBSC_EV_LOSS_SET] = loss_lvl & ~loss_prev_r;
        ev[`CBSC_EV_LOSS_CLR] = ~loss_lvl & loss_prev_r;
        ev[`CBSC_EV_ROTATE]   = rot_pulse;
        ev[`CBSC_EV_PD_REL]   = pin_pd_r & chan_powerdown_n; // prompt for the data path reset
    end

    wire logic                   istat_clr     = rd_done & hit_istat;
    // clear only what the read returned, so an event landing during the access survives
    wire logic [`CBSC_IRQ_W-1:0] rd_seen       = istat_clr ? prdata_r[`CBSC_IRQ_W-1:0] : '0;
    wire logic [`CBSC_IRQ_W-1:0] irq_stat_nxt  = (irq_stat_r & ~rd_seen) | ev;
    wire logic                   irq_nxt       = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] rd_val;

    always_comb begin
        rd_val = '0;
        if (hit_ctrl) begin
            rd_val[`CBSC_CTRL_W-1:0] = ctrl_r;
        end else if (hit_stat) begin
            rd_val[`CBSC_ST_LOSS]    = loss_lvl;
            rd_val[`CBSC_ST_PD]      = pd_r;
            rd_val[`CBSC_ST_REF_ONE] = ref_one_r;
            rd_val[`CBSC_ST_LANE_LO +: LANE_W] = lane_r;
        end else if (hit_istat) begin
            rd_val[`CBSC_IRQ_W-1:0] = irq_stat_r;
        end else if (hit_imask) begin
            rd_val[`CBSC_IRQ_W-1:0] = irq_mask_r;
        end else if (hit_ref) begin
            rd_val[`CBSC_REF_W-1:0] = refsel_r;
        end
    end

    // ------------------------------------------------------------
    // apb handshake flops
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= first_acc;
            pslverr_r <= first_acc & ~hit_any;
            prdata_r  <= (first_acc && !pwrite) ? rd_val : '0;
        end
    end

    // ------------------------------------------------------------
    // software registers, writes land at the completing edge
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= `CBSC_CTRL_RST;
            refsel_r   <= `CBSC_REF_RST;
            irq_mask_r <= `CBSC_IRQ_RST;
        end else begin
            if (wr_done && hit_ctrl) begin
                ctrl_r <= pwdata[`CBSC_CTRL_W-1:0];
            end
            if (wr_done && hit_ref) begin
                refsel_r <= pwdata[`CBSC_REF_W-1:0];
            end
            if (wr_done && hit_imask) begin
                irq_mask_r <= pwdata[`CBSC_IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status and output
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= `CBSC_IRQ_RST;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_r      <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // loss detector and event history
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            los_r       <= CBSC_LOS_PRESENT;
            loss_prev_r <= 1'b0;
            pin_pd_r    <= 1'b0;
        end else begin
            los_r       <= los_nxt;
            loss_prev_r <= loss_lvl;
            pin_pd_r    <= ~chan_powerdown_n;
        end
    end

    // ------------------------------------------------------------
    // pin flops: low and driven through reset
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r      <= 1'b0;
            flag_oe_n_r <= 1'b0;
        end else begin
            flag_r      <= flag_nxt;
            flag_oe_n_r <= flag_oe_n_nxt;
        end
    end

    // ------------------------------------------------------------
    // channel control flops
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_r    <= '0;
            pd_r      <= 1'b0;
            ref_one_r <= 1'b0;
            dp_rst_r  <= 1'b0;
        end else begin
            lane_r    <= lane_nxt;
            pd_r      <= pd_any;
            ref_one_r <= ref_nxt;
            dp_rst_r  <= wr_done & hit_cmd & pwdata[`CBSC_CMD_DP_RST];
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata                   = prdata_r;
    assign pready                   = pready_r;
    assign pslverr                  = pslverr_r;
    assign rx_signal_loss_flag      = flag_r;
    assign rx_signal_loss_flag_oe_n = flag_oe_n_r;
    assign lane_rotate_sel          = lane_r;
    assign chan_powered_down        = pd_r;
    assign ref_sel_one              = ref_one_r;
    assign datapath_reset           = dp_rst_r;
    assign irq                      = irq_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    wire logic loss_path = los_en & (route == CBSC_ROUTE_LOSS) & ~pd_any;

    AST_LOS_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (loss_path && low_swing)[*2] |=> rx_signal_loss_flag)
        else $error("loss flag not set at low swing");

    AST_LOS_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        (loss_path && hi_swing)[*2] |=> !rx_signal_loss_flag)
        else $error("loss flag not clear with signal present");

    AST_LOS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        loss_path && !low_swing && !hi_swing |=> loss_lvl == $past(loss_lvl))
        else $error("loss state moved inside hysteresis band");

    AST_RST_LOW: assert property (@(posedge pclk)
        !presetn |-> !rx_signal_loss_flag && !rx_signal_loss_flag_oe_n)
        else $error("loss pin not driven low in reset");

    AST_PD_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
        pd_any |=> rx_signal_loss_flag_oe_n)
        else $error("loss pin driven during power down");

    AST_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        (route == CBSC_ROUTE_PWRDN) && !pd_any |=> rx_signal_loss_flag == $past(pd_r))
        else $error("routed function not shown on loss pin");

    AST_ROT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        rot_pulse |=> lane_r == (($past(lane_r) == lane_last) ? '0 : $past(lane_inc)))
        else $error("lane did not rotate on jog");

    AST_PIN_PD: assert property (@(posedge pclk) disable iff (!presetn)
        !chan_powerdown_n |=> chan_powered_down ##0 !chan_powerdown_n || !reg_pd || chan_powered_down)
        else $error("channel not powered down by pin");

    AST_PIN_RUN: assert property (@(posedge pclk) disable iff (!presetn)
        chan_powerdown_n && !reg_pd |=> !chan_powered_down)
        else $error("channel held down after pin release");

    AST_REF_PIN: assert property (@(posedge pclk) disable iff (!presetn)
        !sw_mode && !shared_refsel_pin |=> !ref_sel_one)
        else $error("shared pin low did not pick reference zero");

    AST_REF_SW: assert property (@(posedge pclk) disable iff (!presetn)
        sw_mode |=> ref_sel_one == $past(sw_one))
        else $error("software reference choice not applied");

endmodule

`default_nettype wire

// File: tb/cbsc_board_model.sv
// board-side model that drives the channel b control pins
`timescale 1ns/1ps
`default_nettype none
module cbsc_board_model (
    input  wire logic       pclk,
    input  wire logic [9:0] swing_req,
    input  wire logic       jog_req,
    input  wire logic       pd_req,
    input  wire logic       sh_req,
    input  wire logic       cb_req,
    output var  logic [9:0] swing,
    output var  logic       jog,
    output var  logic       pd_n,
    output var  logic       sh,
    output var  logic       cb
);
    // pins start in the run state so nothing is unknown at time zero
    initial begin
        swing = 10'd200;
        jog = 1'b0;
        pd_n = 1'b1;
        sh = 1'b0;
        cb = 1'b0;
    end
    // pins move just after an edge, as real board logic would
    always @(posedge pclk) begin
        swing <= swing_req;
        jog   <= jog ^ jog_req;
        pd_n  <= pd_req;
        sh    <= sh_req;
        cb    <= cb_req;
    end
endmodule
`default_nettype wire

// File: tb/cbsc_top_tb_top.sv
// self-checking bench for the channel b pin block
`timescale 1ns/1ps
`default_nettype none
`include "cbsc_regs.svh"
module cbsc_top_tb_top import cbsc_pkg::*;;
    logic        pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, flag, oe_n, pwd, ref1, dpr, irq, jog, pd_n, sh, cb, dp_seen = 1'b0;
    logic [1:0]  lane;
    logic [9:0]  swing, swing_req = 10'd200;
    logic        jog_req = 1'b0, pd_req = 1'b1, sh_req = 1'b0, cb_req = 1'b0;
    logic [33:0] expq[$];
    logic [33:0] ent;
    logic [9:0]  sw_tab [5] = '{10'd200, 10'd75, 10'd100, 10'd151, 10'd150};
    logic        fl_tab [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [3:0]  rs_tab [5] = '{4'h8, 4'he, 4'h0, 4'h7, 4'h9};
    integer      seed = 32'h8eab4227;
    int          err_total = 0, cmp_count = 0, cyc = 0, i;

    always #12.5 pclk = ~pclk;

    cbsc_board_model cbsc_board_model_inst (.pclk(pclk), .swing_req(swing_req), .jog_req(jog_req),
        .pd_req(pd_req), .sh_req(sh_req), .cb_req(cb_req), .swing(swing), .jog(jog), .pd_n(pd_n),
        .sh(sh), .cb(cb));
    cbsc_top cbsc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hs_rx_swing_mv(swing), .lane_rotate_jog(jog), .chan_powerdown_n(pd_n),
        .shared_refsel_pin(sh), .chan_b_refsel_pin(cb), .rx_signal_loss_flag(flag),
        .rx_signal_loss_flag_oe_n(oe_n), .lane_rotate_sel(lane), .chan_powered_down(pwd),
        .ref_sel_one(ref1), .datapath_reset(dpr), .irq(irq));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // one apb transfer; e = {slverr, compare data, data}
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
        expq.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {2'b00, 32'h0});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {2'b01, d});
    endtask

    // watcher: oldest note against each completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
            ent = expq.pop_front();
            chk({31'h0, pslverr}, {31'h0, ent[33]});
            if (ent[32]) chk(prdata, ent[31:0]);
        end
    end

    // hang guard and data path reset catcher
    always @(posedge pclk) begin
        cyc++;
        if (dpr === 1'b1) dp_seen <= 1'b1;
        if (cyc == 8000) begin
            err_total++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        // a real falling edge at time zero so the pin flops reset before the first clock
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        chk({30'h0, flag, oe_n}, 32'h0);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(`CBSC_OFF_CTRL, 32'h1);
        rd(`CBSC_OFF_REFSEL, 32'h0);
        rd(`CBSC_OFF_IRQ_MASK, 32'h0);
        apb(1'b0, 8'h18, 32'h0, {2'b11, 32'h0});
        chk({31'h0, ref1}, 32'h0);
        // swing table; first entry random but above the clear level
        sw_tab[0] = 10'd151 + 10'($unsigned($random(seed)) % 873);
        for (i = 0; i < 5; i++) begin
            swing_req <= sw_tab[i];
            repeat (6) @(posedge pclk);
            chk({31'h0, flag}, {31'h0, fl_tab[i]});
        end
        rd(`CBSC_OFF_IRQ_STAT, 32'h3);
        rd(`CBSC_OFF_IRQ_STAT, 32'h0);
        // jog both edges and a wrap, irq masked off meanwhile
        for (i = 1; i <= 5; i++) begin
            jog_req <= 1'b1;
            @(posedge pclk);
            jog_req <= 1'b0;
            repeat (8) @(posedge pclk);
            chk({30'h0, lane}, 32'(i % 4));
            chk({31'h0, irq}, 32'h0);
        end
        wr(`CBSC_OFF_IRQ_MASK, 32'h4);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rd(`CBSC_OFF_IRQ_STAT, 32'h4);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // other sources routed onto the loss pin
        sh_req <= 1'b1;
        for (i = 1; i < 4; i++) begin
            wr(`CBSC_OFF_CTRL, 32'(i * 4 + 1));
            repeat (4) @(posedge pclk);
            chk({31'h0, flag}, {31'h0, i != 2});
        end
        wr(`CBSC_OFF_CTRL, 32'h1);
        // reference select: {shared pin, channel pin, software choice, software mode}
        // channel pin high forces reference zero in pin mode
        for (i = 0; i < 5; i++) begin
            sh_req <= rs_tab[i][3];
            cb_req <= rs_tab[i][2];
            wr(`CBSC_OFF_REFSEL, {30'h0, rs_tab[i][1:0]});
            repeat (4) @(posedge pclk);
            chk({31'h0, ref1}, {31'h0, i == 0 || i == 3});
        end
        // pin power down, then register power down
        pd_req <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({30'h0, oe_n, pwd}, 32'h3);
        rd(`CBSC_OFF_STATUS, 32'h12);
        pd_req <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({30'h0, oe_n, pwd}, 32'h0);
        rd(`CBSC_OFF_IRQ_STAT, 32'h8);
        chk({31'h0, dp_seen}, 32'h0);
        wr(`CBSC_OFF_CMD, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, dp_seen}, 32'h1);
        rd(`CBSC_OFF_CMD, 32'h0);
        wr(`CBSC_OFF_CTRL, 32'h3);
        repeat (3) @(posedge pclk);
        chk({30'h0, oe_n, pwd}, 32'h3);
        // second reset in mid-run drives the pin low again
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({29'h0, flag, oe_n, lane != 2'b00}, 32'h0);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        // control back at its reset value, pin driven again
        chk({30'h0, flag, oe_n}, 32'h0);
        rd(`CBSC_OFF_CTRL, 32'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
